// File: core/cte_pkg.sv
package cte_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses on the wishbone slave
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_PC     = 8'h08;
  localparam logic [7:0] ADR_ACC_D  = 8'h0c;
  localparam logic [7:0] ADR_ACC_E  = 8'h10;
  localparam logic [7:0] ADR_IX     = 8'h14;
  localparam logic [7:0] ADR_IY     = 8'h18;
  localparam logic [7:0] ADR_IZ     = 8'h1c;
  localparam logic [7:0] ADR_SP     = 8'h20;
  localparam logic [7:0] ADR_EXT    = 8'h24;
  localparam logic [7:0] ADR_AM_LO  = 8'h28;
  localparam logic [7:0] ADR_AM_HI  = 8'h2c;
  localparam logic [7:0] ADR_FLAGS  = 8'h30;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_STEP_BIT   = 0;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_ILLEGAL_BIT = 1;
  localparam int STAT_CYC_LSB    = 8;
  localparam int FLG_MV  = 14;
  localparam int FLG_EV  = 12;
  localparam int FLG_N   = 11;
  localparam int FLG_Z   = 10;
  localparam int FLG_V   = 9;
  localparam int FLG_C   = 8;
  localparam int FLG_SM  = 4;

  // ----------------------------------------------------------------
  // reset values, opcodes, constants
  // ----------------------------------------------------------------
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] SAT_POS     = 16'h7fff;
  localparam logic [15:0] SAT_NEG     = 16'h8000;
  localparam logic [19:0] SP_STEP     = 20'h00002;
  localparam logic [7:0]  PAGE_17 = 8'h17;
  localparam logic [7:0]  PAGE_27 = 8'h27;
  localparam logic [7:0]  PAGE_37 = 8'h37;
  localparam logic [7:0]  CYC_SHORT = 8'h02;
  localparam logic [7:0]  CYC_LONG  = 8'h06;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NONE, OP_MAC_TO_E_TRUNCATE, OP_MAC_TO_INDEX_AND_ACCUMS, OP_FLAGS_HIGH_TO_ACC_A,
    OP_FLAGS_TO_ACC_D, OP_EXT_TO_ACC_B, OP_MEMORY_BYTE_TEST, OP_MEMORY_WORD_TEST,
    OP_ACC_A_TEST, OP_ACC_B_TEST, OP_ACC_D_TEST, OP_ACC_E_TEST,
    OP_STACK_TO_INDEX, OP_INDEX_TO_STACK, OP_XINDEX_TO_INDEX
  } cte_op_t;

  typedef enum logic [1:0] {MODE_INH, MODE_IND8, MODE_IND16, MODE_EXT} cte_mode_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_OPC  = 7'b0000010,
    ST_OPC2 = 7'b0000100,
    ST_DEC  = 7'b0001000,
    ST_OPND = 7'b0010000,
    ST_MEM  = 7'b0100000,
    ST_EXEC = 7'b1000000
  } cte_state_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] accD;
    logic [15:0] accE;
    logic [15:0] ix;
    logic [15:0] iy;
    logic [15:0] iz;
    logic [15:0] sp;
    logic [3:0]  ek;
    logic [3:0]  sk;
    logic [3:0]  zk;
    logic [3:0]  yk;
    logic [3:0]  xk;
    logic [35:0] macAccumulator;
    logic [15:0] conditionFlags;
  } cte_regs_t;

endpackage

// File: core/cte_core.sv
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
// Behaviour
// RULE_01: 27B5 loads E with saturation if enabled and overflowed, else MAC bits 31:16.
// RULE_02: 27B3 puts sign-extended MAC 35:32 in X, 31:16 in E, 15:0 in D.
// RULE_03: 37FC copies flags high byte to A; 372C copies all flags to D.
// RULE_04: 37AF/37AC/37AD copy stack/X/Y extension into B low nibble, clear high nibble.
// RULE_05: byte test on memory sets N,Z, clears V,C; 8-bit, 16-bit or extended address.
// RULE_06: 3706/3716 test A or B: set N,Z, clear V and C, two cycles.
// RULE_07: 27F6/2776 test D or E: set N,Z, clear V and C, two cycles.
// RULE_08: word test reads two consecutive bytes, sets N,Z, clears V,C, six cycles.
// RULE_09: 274F/275F/276F load extended X/Y/Z with extended stack pointer plus two.
// RULE_10: 374E/375E load extended stack pointer with extended X or Y minus two.
// RULE_11: 275C/276C copy extended X, extension included, into extended Y or Z.
// RULE_12: saturation enable and both overflow indicators live in the flags register.
// RULE_13: first byte 17, 27 or 37 is a page prefix; second byte then fetched.
module cte_core
  import cte_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             fetchReq,
  output logic      [15:0] fetchAddr,
  input  wire logic        fetchValid,
  input  wire logic [7:0]  fetchByte,
  output logic             memReq,
  output logic      [19:0] memAddr,
  input  wire logic        memValid,
  input  wire logic [7:0]  memByte
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge for wishbone writes
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wr,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[i*8 +: 8] = wr[i*8 +: 8];
    return res;
  endfunction

  // zero-or-minus test: n,z from operand, v,c cleared
  function automatic logic [15:0] testFlags(input logic [15:0] flg, input logic neg, input logic zero);
    logic [15:0] res;
    res = flg;
    res[FLG_N] = neg;
    res[FLG_Z] = zero;
    res[FLG_V] = 1'b0;
    res[FLG_C] = 1'b0;
    return res;
  endfunction

  // opcode to operation, page byte in the upper half
  function automatic cte_op_t decodeOp(input logic [15:0] code);
    cte_op_t op;
    op = OP_NONE;
    case (code)
      16'h27b5:                                 op = OP_MAC_TO_E_TRUNCATE;
      16'h27b3:                                 op = OP_MAC_TO_INDEX_AND_ACCUMS;
      16'h37fc:                                 op = OP_FLAGS_HIGH_TO_ACC_A;
      16'h372c:                                 op = OP_FLAGS_TO_ACC_D;
      16'h37af, 16'h37ac, 16'h37ad:             op = OP_EXT_TO_ACC_B;
      16'h0006, 16'h0016, 16'h0026,
      16'h1706, 16'h1716, 16'h1726, 16'h1736:   op = OP_MEMORY_BYTE_TEST;
      16'h2706, 16'h2716, 16'h2726, 16'h2736:   op = OP_MEMORY_WORD_TEST;
      16'h3706:                                 op = OP_ACC_A_TEST;
      16'h3716:                                 op = OP_ACC_B_TEST;
      16'h27f6:                                 op = OP_ACC_D_TEST;
      16'h2776:                                 op = OP_ACC_E_TEST;
      16'h274f, 16'h275f, 16'h276f:             op = OP_STACK_TO_INDEX;
      16'h374e, 16'h375e:                       op = OP_INDEX_TO_STACK;
      16'h275c, 16'h276c:                       op = OP_XINDEX_TO_INDEX;
      default:                                  op = OP_NONE;
    endcase
    return op;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cte_regs_t   regs_reg,    regs_next;
  cte_state_t  state_reg,   state_next;
  logic [15:0] code_reg,    code_next;
  logic [15:0] opnd_reg,    opnd_next;
  logic [15:0] memData_reg, memData_next;
  logic [19:0] ea_reg,      ea_next;
  logic [1:0]  left_reg,    left_next;
  logic [7:0]  cnt_reg,     cnt_next;
  logic [7:0]  lastCyc_reg, lastCyc_next;
  logic        illegal_reg, illegal_next;
  logic        ack_reg,     ack_next;
  logic [31:0] rdat_reg,    rdat_next;

  logic        busAccess;
  logic        stepReq;
  cte_op_t     op;
  cte_mode_t   mode;
  logic [7:0]  needCyc;
  logic [19:0] baseAddr;
  logic [19:0] spExt;
  logic [19:0] xExt;
  logic [19:0] srcExt;
  logic [15:0] satSel;
  logic [3:0]  extSel;
  logic [31:0] wrWord;

  // ----------------------------------------------------------------
  // decode of the held code
  // ----------------------------------------------------------------
  always_comb
  begin
    op = decodeOp(code_reg);
    // bits 5:4 of the code pick X, Y, Z or extended
    if (code_reg[15:8] == 8'h00)
      mode = MODE_IND8;
    else if (code_reg[5:4] == 2'b11)
      mode = MODE_EXT;
    else
      mode = MODE_IND16;
    if (op != OP_MEMORY_BYTE_TEST && op != OP_MEMORY_WORD_TEST)
      mode = MODE_INH;
    needCyc = (op == OP_MEMORY_BYTE_TEST || op == OP_MEMORY_WORD_TEST
               || op == OP_MAC_TO_INDEX_AND_ACCUMS) ? CYC_LONG : CYC_SHORT;
    unique case (code_reg[5:4])
      2'b00:   baseAddr = {regs_reg.xk, regs_reg.ix};
      2'b01:   baseAddr = {regs_reg.yk, regs_reg.iy};
      2'b10:   baseAddr = {regs_reg.zk, regs_reg.iz};
      2'b11:   baseAddr = {regs_reg.ek, 16'h0000};
    endcase
    spExt  = {regs_reg.sk, regs_reg.sp};
    xExt   = {regs_reg.xk, regs_reg.ix};
    srcExt = code_reg[4] ? {regs_reg.yk, regs_reg.iy} : xExt;
    satSel = regs_reg.macAccumulator[35] ? SAT_NEG : SAT_POS;
    unique case (code_reg[1:0])
      2'b11:   extSel = regs_reg.sk;
      2'b00:   extSel = regs_reg.xk;
      2'b01:   extSel = regs_reg.yk;
      2'b10:   extSel = regs_reg.zk;
    endcase
  end

  // ----------------------------------------------------------------
  // bus access and port outputs
  // ----------------------------------------------------------------
  assign busAccess = wb_cyc_i && wb_stb_i && !ack_reg;
  assign stepReq   = busAccess && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_STEP_BIT];
  assign wb_ack_o  = ack_reg;
  assign wb_dat_o  = rdat_reg;
  assign fetchReq  = state_reg == ST_OPC || state_reg == ST_OPC2 || state_reg == ST_OPND;
  assign fetchAddr = regs_reg.pc;
  assign memReq    = state_reg == ST_MEM;
  assign memAddr   = ea_reg;

  // ----------------------------------------------------------------
  // sequencer and execution
  // ----------------------------------------------------------------
  always_comb
  begin
    regs_next    = regs_reg;
    state_next   = state_reg;
    code_next    = code_reg;
    opnd_next    = opnd_reg;
    memData_next = memData_reg;
    ea_next      = ea_reg;
    left_next    = left_reg;
    lastCyc_next = lastCyc_reg;
    illegal_next = illegal_reg;
    cnt_next     = (state_reg == ST_IDLE) ? 8'h00 : cnt_reg + 8'h01;
    wrWord       = 32'h0000_0000;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (stepReq)
        begin
          illegal_next = 1'b0;
          state_next   = ST_OPC;
        end
      end
      ST_OPC:
      begin
        if (fetchValid)
        begin
          regs_next.pc = regs_reg.pc + 16'h0001;
          code_next    = {8'h00, fetchByte};
          // page prefix means a second opcode byte follows
          if (fetchByte == PAGE_17 || fetchByte == PAGE_27 || fetchByte == PAGE_37) // [RULE_13]
            state_next = ST_OPC2;
          else
            state_next = ST_DEC;
        end
      end
      ST_OPC2:
      begin
        if (fetchValid)
        begin
          regs_next.pc = regs_reg.pc + 16'h0001;
          code_next    = {code_reg[7:0], fetchByte}; // [RULE_13]
          state_next   = ST_DEC;
        end
      end
      ST_DEC:
      begin
        opnd_next = 16'h0000;
        left_next = (mode == MODE_IND8) ? 2'd1 : 2'd2;
        if (op == OP_NONE)
        begin
          // unknown code: flag it, record the cycle count and stop; no register is written
          illegal_next = 1'b1;
          lastCyc_next = cnt_next;
          state_next   = ST_IDLE;
        end
        else if (mode == MODE_INH)
          state_next = ST_EXEC;
        else
          state_next = ST_OPND;
      end
      ST_OPND:
      begin
        if (fetchValid)
        begin
          regs_next.pc = regs_reg.pc + 16'h0001;
          opnd_next    = {opnd_reg[7:0], fetchByte};
          left_next    = left_reg - 2'd1;
          if (left_reg == 2'd1)
          begin
            // 8-bit offset unsigned, 16-bit offset signed, extended takes the bank field
            unique case (mode)
              MODE_IND8:  ea_next = baseAddr + {12'h000, fetchByte}; // [RULE_05]
              MODE_IND16: ea_next = baseAddr + {{4{opnd_reg[7]}}, opnd_reg[7:0], fetchByte};
              MODE_EXT:   ea_next = {regs_reg.ek, opnd_reg[7:0], fetchByte};
              MODE_INH:   ea_next = ea_reg;
            endcase
            left_next  = (op == OP_MEMORY_WORD_TEST) ? 2'd2 : 2'd1;
            state_next = ST_MEM;
          end
        end
      end
      ST_MEM:
      begin
        if (memValid)
        begin
          // high byte at the lower address comes first
          memData_next = {memData_reg[7:0], memByte}; // [RULE_08]
          ea_next      = ea_reg + 20'h00001;
          left_next    = left_reg - 2'd1;
          if (left_reg == 2'd1)
            state_next = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        // hold here until the instruction's cycle count is reached
        if (cnt_next >= needCyc)
        begin
          lastCyc_next = cnt_next;
          state_next   = ST_IDLE;
          unique case (op)
            OP_MAC_TO_E_TRUNCATE:
              if (regs_reg.conditionFlags[FLG_SM]
                  && (regs_reg.conditionFlags[FLG_EV] || regs_reg.conditionFlags[FLG_MV])) // [RULE_12]
                regs_next.accE = satSel; // [RULE_01]
              else
                regs_next.accE = regs_reg.macAccumulator[31:16]; // [RULE_01]
            OP_MAC_TO_INDEX_AND_ACCUMS:
            begin
              regs_next.ix   = {{12{regs_reg.macAccumulator[35]}}, regs_reg.macAccumulator[35:32]}; // [RULE_02]
              regs_next.accE = regs_reg.macAccumulator[31:16]; // [RULE_02]
              regs_next.accD = regs_reg.macAccumulator[15:0];
            end
            OP_FLAGS_HIGH_TO_ACC_A:
              regs_next.accD[15:8] = regs_reg.conditionFlags[15:8]; // [RULE_03]
            OP_FLAGS_TO_ACC_D:
              regs_next.accD = regs_reg.conditionFlags; // [RULE_03]
            OP_EXT_TO_ACC_B:
              regs_next.accD[7:0] = {4'h0, extSel}; // [RULE_04]
            OP_MEMORY_BYTE_TEST:
              regs_next.conditionFlags = testFlags(regs_reg.conditionFlags, memData_reg[7],
                                                   memData_reg[7:0] == 8'h00); // [RULE_05]
            OP_MEMORY_WORD_TEST:
              regs_next.conditionFlags = testFlags(regs_reg.conditionFlags, memData_reg[15],
                                                   memData_reg == 16'h0000); // [RULE_08]
            OP_ACC_A_TEST:
              regs_next.conditionFlags = testFlags(regs_reg.conditionFlags, regs_reg.accD[15],
                                                   regs_reg.accD[15:8] == 8'h00); // [RULE_06]
            OP_ACC_B_TEST:
              regs_next.conditionFlags = testFlags(regs_reg.conditionFlags, regs_reg.accD[7],
                                                   regs_reg.accD[7:0] == 8'h00); // [RULE_06]
            OP_ACC_D_TEST:
              regs_next.conditionFlags = testFlags(regs_reg.conditionFlags, regs_reg.accD[15],
                                                   regs_reg.accD == 16'h0000); // [RULE_07]
            OP_ACC_E_TEST:
              regs_next.conditionFlags = testFlags(regs_reg.conditionFlags, regs_reg.accE[15],
                                                   regs_reg.accE == 16'h0000); // [RULE_07]
            OP_STACK_TO_INDEX:
              unique case (code_reg[5:4])
                2'b00:   {regs_next.xk, regs_next.ix} = spExt + SP_STEP; // [RULE_09]
                2'b01:   {regs_next.yk, regs_next.iy} = spExt + SP_STEP; // [RULE_09]
                default: {regs_next.zk, regs_next.iz} = spExt + SP_STEP; // [RULE_09]
              endcase
            OP_INDEX_TO_STACK:
              {regs_next.sk, regs_next.sp} = srcExt - SP_STEP; // [RULE_10]
            OP_XINDEX_TO_INDEX:
              if (code_reg[5:4] == 2'b01)
                {regs_next.yk, regs_next.iy} = xExt; // [RULE_11]
              else
                {regs_next.zk, regs_next.iz} = xExt; // [RULE_11]
            OP_NONE:
              illegal_next = 1'b1;
          endcase
        end
      end
    endcase
    // software writes land only while the core is idle, so no race with execution
    if (busAccess && wb_we_i && state_reg == ST_IDLE)
    begin
      unique case (wb_adr_i)
        ADR_PC:    regs_next.pc   = 16'(laneMerge({16'h0000, regs_reg.pc}, wb_dat_i, wb_sel_i));
        ADR_ACC_D: regs_next.accD = 16'(laneMerge({16'h0000, regs_reg.accD}, wb_dat_i, wb_sel_i));
        ADR_ACC_E: regs_next.accE = 16'(laneMerge({16'h0000, regs_reg.accE}, wb_dat_i, wb_sel_i));
        ADR_IX:    regs_next.ix   = 16'(laneMerge({16'h0000, regs_reg.ix}, wb_dat_i, wb_sel_i));
        ADR_IY:    regs_next.iy   = 16'(laneMerge({16'h0000, regs_reg.iy}, wb_dat_i, wb_sel_i));
        ADR_IZ:    regs_next.iz   = 16'(laneMerge({16'h0000, regs_reg.iz}, wb_dat_i, wb_sel_i));
        ADR_SP:    regs_next.sp   = 16'(laneMerge({16'h0000, regs_reg.sp}, wb_dat_i, wb_sel_i));
        ADR_EXT:
        begin
          wrWord = laneMerge({12'h000, regs_reg.ek, regs_reg.sk, regs_reg.zk, regs_reg.yk, regs_reg.xk},
                             wb_dat_i, wb_sel_i);
          {regs_next.ek, regs_next.sk, regs_next.zk, regs_next.yk, regs_next.xk} = wrWord[19:0];
        end
        ADR_AM_LO: regs_next.macAccumulator[31:0] = laneMerge(regs_reg.macAccumulator[31:0], wb_dat_i, wb_sel_i);
        ADR_AM_HI:
        begin
          wrWord = laneMerge({28'h0000000, regs_reg.macAccumulator[35:32]}, wb_dat_i, wb_sel_i);
          regs_next.macAccumulator[35:32] = wrWord[3:0];
        end
        ADR_FLAGS: regs_next.conditionFlags = 16'(laneMerge({16'h0000, regs_reg.conditionFlags}, wb_dat_i, wb_sel_i));
        default:   wrWord = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // wishbone answer: one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  always_comb
  begin
    ack_next  = busAccess;
    rdat_next = rdat_reg;
    if (busAccess && !wb_we_i)
    begin
      unique case (wb_adr_i)
        ADR_STATUS: rdat_next = {16'h0000, lastCyc_reg, 6'h00, illegal_reg, state_reg != ST_IDLE};
        ADR_PC:     rdat_next = {16'h0000, regs_reg.pc};
        ADR_ACC_D:  rdat_next = {16'h0000, regs_reg.accD};
        ADR_ACC_E:  rdat_next = {16'h0000, regs_reg.accE};
        ADR_IX:     rdat_next = {16'h0000, regs_reg.ix};
        ADR_IY:     rdat_next = {16'h0000, regs_reg.iy};
        ADR_IZ:     rdat_next = {16'h0000, regs_reg.iz};
        ADR_SP:     rdat_next = {16'h0000, regs_reg.sp};
        ADR_EXT:    rdat_next = {12'h000, regs_reg.ek, regs_reg.sk, regs_reg.zk, regs_reg.yk, regs_reg.xk};
        ADR_AM_LO:  rdat_next = regs_reg.macAccumulator[31:0];
        ADR_AM_HI:  rdat_next = {28'h0000000, regs_reg.macAccumulator[35:32]};
        ADR_FLAGS:  rdat_next = {16'h0000, regs_reg.conditionFlags};
        default:    rdat_next = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      regs_reg    <= '{conditionFlags: FLAGS_RESET, default: '0};
      state_reg   <= ST_IDLE;
      code_reg    <= 16'h0000;
      opnd_reg    <= 16'h0000;
      memData_reg <= 16'h0000;
      ea_reg      <= 20'h00000;
      left_reg    <= 2'd0;
      cnt_reg     <= 8'h00;
      lastCyc_reg <= 8'h00;
      illegal_reg <= 1'b0;
      ack_reg     <= 1'b0;
      rdat_reg    <= 32'h0000_0000;
    end
    else
    begin
      regs_reg    <= regs_next;
      state_reg   <= state_next;
      code_reg    <= code_next;
      opnd_reg    <= opnd_next;
      memData_reg <= memData_next;
      ea_reg      <= ea_next;
      left_reg    <= left_next;
      cnt_reg     <= cnt_next;
      lastCyc_reg <= lastCyc_next;
      illegal_reg <= illegal_next;
      ack_reg     <= ack_next;
      rdat_reg    <= rdat_next;
    end
  end

endmodule

// File: sim/cte_chk.sv
`timescale 1ns/1ns
module cte_chk
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        fetchReq,
  input wire logic [15:0] fetchAddr,
  input wire logic        fetchValid,
  input wire logic        memReq,
  input wire logic [19:0] memAddr,
  input wire logic        memValid
);
  // ------------------------------
  // port protocol checks
  // ------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  property p_ack; s_take |=> wb_ack_o; endproperty
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_excl; !(fetchReq && memReq); endproperty
  property p_fhold; fetchReq && !fetchValid |=> fetchReq && $stable(fetchAddr); endproperty
  property p_fstep; fetchReq && fetchValid |=> fetchAddr == $past(fetchAddr) + 16'h0001; endproperty
  property p_mhold; memReq && !memValid |=> memReq && $stable(memAddr); endproperty
  property p_mstep; memReq && memValid |=> memAddr == $past(memAddr) + 20'h00001; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  a_cause: assert property (p_cause) else $error("ack without request");
  a_excl: assert property (p_excl) else $error("fetch and operand request together");
  a_fhold: assert property (p_fhold) else $error("fetch request dropped or moved");
  a_fstep: assert property (p_fstep) else $error("fetch address did not step");
  a_mhold: assert property (p_mhold) else $error("operand request dropped or moved");
  a_mstep: assert property (p_mstep) else $error("operand address did not step");
endmodule

// File: sim/cte_mem_model.sv
`timescale 1ns/1ns
module cte_mem_model
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        slow,
  input  wire logic        fetchReq,
  input  wire logic [15:0] fetchAddr,
  output logic             fetchValid,
  output logic      [7:0]  fetchByte,
  input  wire logic        memReq,
  input  wire logic [19:0] memAddr,
  output logic             memValid,
  output logic      [7:0]  memByte
);
  // ------------------------------
  // program and operand memory
  // ------------------------------
  logic [7:0] prog [256];
  logic [7:0] data [256];
  logic [1:0] waitCnt;
  // slow mode waits three idle cycles per byte
  wire fGo = fetchReq && !fetchValid && (!slow || waitCnt == 2'h3);
  wire mGo = memReq && !memValid && (!slow || waitCnt == 2'h3);
  // idle lines toggle so stale bytes never pass as data
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      waitCnt <= 2'h0;
      fetchValid <= 1'b0;
      memValid <= 1'b0;
      fetchByte <= 8'h00;
      memByte <= 8'h00;
    end
    else
    begin
      waitCnt <= (fetchReq || memReq) && !fGo && !mGo ? waitCnt + 2'h1 : 2'h0;
      fetchValid <= fGo;
      memValid <= mGo;
      fetchByte <= fGo ? prog[fetchAddr[7:0]] : ~fetchByte;
      memByte <= mGo ? data[memAddr[7:0]] : ~memByte;
    end
endmodule

// File: sim/cte_core_bench.sv
`timescale 1ns/1ns
module cte_core_bench
  import cte_pkg::*;
;
  logic core_clk, arst_n, wb_ack_o, fetchReq, fetchValid, memReq, memValid;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, slow = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, fetchByte, memByte;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [15:0] fetchAddr;
  logic [19:0] memAddr;
  int err_count = 0, num_checks = 0;
  cte_core u_dut (.*);
  cte_mem_model u_mem (.*);
  // ------------------------------
  // bus and check tasks
  // ------------------------------
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(negedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    @(posedge core_clk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbx(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wbx(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // place code at pc, step once, poll busy until idle
  task automatic run(input logic [31:0] code, input int nb, input logic [7:0] cyc);
    logic [31:0] st;
    for (int i = 0; i < nb; i++) u_mem.prog[i] = code[31-8*i -: 8];
    wr(ADR_PC, 32'h0);
    wr(ADR_CTRL, 32'h1);
    do wbx(1'b0, ADR_STATUS, 32'h0, st); while (st[STAT_BUSY_BIT] !== 1'b0);
    chk({st[STAT_ILLEGAL_BIT], st[15:8] >= cyc}, {cyc == 8'h00, 1'b1});
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_tests();
    logic [31:0] op [8] = '{32'h3706_0000, 32'h3716_0000, 32'h27f6_0000, 32'h2776_0000,
      32'h0605_0000, 32'h1736_0040, 32'h2736_0050, 32'h2706_fff0};
    logic [15:0] fl [8] = '{16'h0800, 16'h0400, 16'h0800, 16'h0000, 16'h0400, 16'h0800, 16'h0000, 16'h0800};
    wr(ADR_ACC_D, 32'h8000);
    wr(ADR_ACC_E, 32'h0001);
    wr(ADR_IX, 32'h0010);
    u_mem.data[8'h15] = 8'h00;
    u_mem.data[8'h40] = 8'h90;
    u_mem.data[8'h50] = 8'h00;
    u_mem.data[8'h51] = 8'h01;
    u_mem.data[8'h00] = 8'h80;
    u_mem.data[8'h01] = 8'h00;
    foreach (op[i])
    begin
      slow <= i[2]; // memory forms run against a slow memory
      wr(ADR_FLAGS, 32'h0300);
      run(op[i], i < 5 ? 2 : 4, i < 4 ? CYC_SHORT : CYC_LONG);
      rd(ADR_FLAGS, {16'h0, fl[i]});
    end
    slow <= 1'b0;
    $display("zero tests done");
  endtask
  task automatic t_mac();
    wr(ADR_AM_LO, 32'h1234_5678);
    wr(ADR_AM_HI, 32'h9);
    run(32'h27b3_0000, 2, CYC_LONG);
    rd(ADR_IX, 32'hfff9);
    rd(ADR_ACC_E, 32'h1234);
    rd(ADR_ACC_D, 32'h5678);
    wr(ADR_FLAGS, 32'h4010);
    run(32'h27b5_0000, 2, CYC_SHORT);
    rd(ADR_ACC_E, 32'h8000);
    wr(ADR_FLAGS, 32'h0);
    run(32'h27b5_0000, 2, CYC_SHORT);
    rd(ADR_ACC_E, 32'h1234);
    wr(ADR_AM_HI, 32'h0);
    wr(ADR_FLAGS, 32'h1010);
    run(32'h27b5_0000, 2, CYC_SHORT);
    rd(ADR_ACC_E, 32'h7fff);
    $display("mac moves done");
  endtask
  task automatic t_xfer();
    wr(ADR_FLAGS, 32'h4a10);
    run(32'h372c_0000, 2, CYC_SHORT);
    rd(ADR_ACC_D, 32'h4a10);
    wr(ADR_ACC_D, 32'h00ff);
    run(32'h37fc_0000, 2, CYC_SHORT);
    rd(ADR_ACC_D, 32'h4aff);
    wr(ADR_EXT, 32'h5_4321);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADR_ACC_D, 32'hffff);
      run({8'h37, 8'hac + i[7:0] + {7'h0, i[1]}, 16'h0}, 2, CYC_SHORT);
      rd(ADR_ACC_D, {24'h00ff, 4'h0, 4'h1 << i});
    end
    wr(ADR_FLAGS, 32'h0f00);
    wr(ADR_SP, 32'hfffe);
    wr(ADR_EXT, 32'h0_4000);
    run(32'h274f_0000, 2, CYC_SHORT);
    rd(ADR_IX, 32'h0);
    run(32'h275c_0000, 2, CYC_SHORT);
    run(32'h276c_0000, 2, CYC_SHORT);
    wr(ADR_SP, 32'h0);
    run(32'h374e_0000, 2, CYC_SHORT);
    rd(ADR_SP, 32'hfffe);
    rd(ADR_EXT, 32'h0_4555);
    rd(ADR_FLAGS, 32'h0f00);
    run(32'h27ff_0000, 2, 8'h00);
    rd(ADR_PC, 32'h2);
    rd(8'hfc, 32'h0);
    $display("transfers done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // watchdog ends a hang
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    summarize();
  end
  initial
  begin
    arst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    t_tests();
    t_mac();
    t_xfer();
    summarize();
  end
endmodule
bind cte_core cte_chk u_chk (.*);
